// ---- include/bwpp_pkg.sv ----
// shared constants, opcodes, timing and helpers for the buffer write / page program link
package bwpp_pkg;

  // buffer load opcodes
  localparam logic [7:0] OP_LOAD1_BUF1 = 8'h84;
  localparam logic [7:0] OP_LOAD1_BUF2 = 8'h87;
  localparam logic [7:0] OP_LOAD2_BUF1 = 8'h24;
  localparam logic [7:0] OP_LOAD2_BUF2 = 8'h27;
  localparam logic [7:0] OP_LOAD4_BUF1 = 8'h44;
  localparam logic [7:0] OP_LOAD4_BUF2 = 8'h47;
  // buffer to page program opcodes
  localparam logic [7:0] OP_EPROG_BUF1 = 8'h83;
  localparam logic [7:0] OP_EPROG_BUF2 = 8'h86;
  localparam logic [7:0] OP_PROG_BUF1 = 8'h88;
  localparam logic [7:0] OP_PROG_BUF2 = 8'h89;
  localparam logic [7:0] OP_THRU_BUF1 = 8'h82;
  localparam logic [7:0] OP_THRU_BUF2 = 8'h85;

  // frame layout
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam int HDR_BYTES = 4;
  localparam int PAGE_BITS = 13;
  localparam int BUF_ADR_BITS = 10;
  localparam int BIN_BUF_BITS = 9;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam logic [9:0] BUF_SIZE_STD = 10'h210;
  localparam logic [9:0] BUF_SIZE_BIN = 10'h200;
  localparam int BUF_WORDS = 1056;

  // timing, in ns and in system clock cycles
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int ERASE_TIME_NS = 4000;
  localparam int BYTE_PROG_TIME_NS = 12;
  localparam int CS_GAP_NS = 20;
  localparam logic [11:0] ERASE_CYC = 12'(ERASE_TIME_NS / SYS_CLK_PERIOD_NS);
  localparam logic [11:0] BYTE_PROG_CYC = 12'(BYTE_PROG_TIME_NS / SYS_CLK_PERIOD_NS);
  localparam logic [3:0] CS_GAP_CYC =
    4'((CS_GAP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_ERASE = 3'b010,
    DEV_PROG = 3'b100
  } bwpp_dev_state_t;

  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_LOAD = 5'b00010,
    HST_LOW = 5'b00100,
    HST_HIGH = 5'b01000,
    HST_END = 5'b10000
  } bwpp_hst_state_t;

  // data lanes used in the data phase, zero for commands without data
  function automatic logic [2:0] op_lanes(input logic [7:0] op);
    case (op)
      OP_LOAD1_BUF1, OP_LOAD1_BUF2, OP_THRU_BUF1, OP_THRU_BUF2: op_lanes = 3'h1;
      OP_LOAD2_BUF1, OP_LOAD2_BUF2: op_lanes = 3'h2;
      OP_LOAD4_BUF1, OP_LOAD4_BUF2: op_lanes = 3'h4;
      default: op_lanes = 3'h0;
    endcase
  endfunction

  function automatic logic op_buf2(input logic [7:0] op);
    op_buf2 = op inside {OP_LOAD1_BUF2, OP_LOAD2_BUF2, OP_LOAD4_BUF2,
                         OP_EPROG_BUF2, OP_PROG_BUF2, OP_THRU_BUF2};
  endfunction

  function automatic logic op_program(input logic [7:0] op);
    op_program = op inside {OP_EPROG_BUF1, OP_EPROG_BUF2, OP_PROG_BUF1, OP_PROG_BUF2,
                            OP_THRU_BUF1, OP_THRU_BUF2};
  endfunction

  function automatic logic op_erases(input logic [7:0] op);
    op_erases = op inside {OP_EPROG_BUF1, OP_EPROG_BUF2, OP_THRU_BUF1, OP_THRU_BUF2};
  endfunction

endpackage

// ---- include/bwpp_if.sv ----
// serial link between host controller and flash sequencer
interface bwpp_if;
  logic cs_n;
  logic sclk;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] io;

  // lines nobody drives are held high by pull-ups
  assign io = ~io_oe | io_out;

  modport host (output cs_n, output sclk, output io_out, output io_oe);
  modport dev (input cs_n, input sclk, input io);
endinterface

// ---- rtl/bwpp_device.sv ----
// flash sequencer end: buffer loads on the link clock, page commit on the system clock
module bwpp_device (
  // serial link, clocked by the host
  bwpp_if.dev link,
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input wire logic quad_width_enable_bit,
  input wire logic binary_page_size,
  // fault report from the array
  input wire logic cell_fail,
  // status
  output logic ready_flag,
  output logic erase_program_error_flag,
  // array write port
  output logic array_erase,
  output logic array_prog_we,
  output logic [bwpp_pkg::PAGE_BITS-1:0] main_page_address,
  output logic [bwpp_pkg::BUF_ADR_BITS-1:0] buffer_byte_address,
  output logic [7:0] array_data
);
  import bwpp_pkg::*;

  // link domain
  logic qe_meta_reg;
  logic qe_reg;
  logic bin_meta_reg;
  logic bin_reg;
  logic in_frame_reg;
  logic frame_tog_reg, frame_tog_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [3:0] lane_cnt_reg, lane_cnt_next;
  logic [7:0] op_reg, op_next;
  logic [23:0] adr_reg, adr_next;
  logic [9:0] ptr_reg, ptr_next;
  logic [7:0] sh_reg, sh_next;
  logic [5:0] bcnt;
  logic [2:0] lanes;
  logic [3:0] filled;
  logic [23:0] adr_full;
  logic [9:0] link_size;
  logic mem_we;
  logic [10:0] mem_idx;
  logic [7:0] mem_wdata;
  logic [7:0] buf_mem [0:BUF_WORDS-1];

  always_ff @(posedge link.sclk) begin
    qe_meta_reg <= quad_width_enable_bit;
    qe_reg <= qe_meta_reg;
    bin_meta_reg <= binary_page_size;
    bin_reg <= bin_meta_reg;
  end

  // the clock stops between frames, so frame start is marked by select alone
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  always_comb begin
    bcnt = in_frame_reg ? bit_cnt_reg : 6'h00;
    frame_tog_next = in_frame_reg ? frame_tog_reg : ~frame_tog_reg;
    bit_cnt_next = bcnt;
    op_next = op_reg;
    adr_next = adr_reg;
    ptr_next = ptr_reg;
    sh_next = sh_reg;
    lane_cnt_next = lane_cnt_reg;
    mem_we = 1'b0;
    mem_wdata = sh_reg;
    mem_idx = 11'h000;
    lanes = op_lanes(op_reg);
    if (lanes == 3'h4 && !qe_reg) begin
      lanes = 3'h0;
    end
    link_size = bin_reg ? BUF_SIZE_BIN : BUF_SIZE_STD;
    adr_full = {adr_reg[22:0], link.io[0]};
    filled = lane_cnt_reg + {1'b0, lanes};
    if (bcnt < HDR_BITS) begin
      bit_cnt_next = bcnt + 6'h01;
      if (bcnt < OPCODE_BITS) begin
        op_next = {op_reg[6:0], link.io[0]};
      end else begin
        adr_next = adr_full;
      end
      if (bcnt == HDR_BITS - 6'h01) begin
        lane_cnt_next = 4'h0;
        if (bin_reg) begin
          ptr_next = {1'b0, adr_full[BIN_BUF_BITS-1:0]};
        end else begin
          ptr_next = adr_full[BUF_ADR_BITS-1:0];
        end
        // an address past the last byte starts at byte zero
        if (ptr_next >= link_size) begin
          ptr_next = 10'h000;
        end
      end
    end else if (lanes != 3'h0) begin
      case (lanes)
        3'h1: sh_next = {sh_reg[6:0], link.io[0]};
        3'h2: sh_next = {sh_reg[5:0], link.io[1:0]};
        default: sh_next = {sh_reg[3:0], link.io[3:0]};
      endcase
      lane_cnt_next = filled;
      if (filled == 4'h8) begin
        lane_cnt_next = 4'h0;
        mem_we = 1'b1;
        mem_wdata = sh_next;
        mem_idx = {1'b0, ptr_reg} + (op_buf2(op_reg) ? {1'b0, BUF_SIZE_STD} : 11'h000);
        ptr_next = (ptr_reg == link_size - 10'h001) ? 10'h000 : ptr_reg + 10'h001;
      end
    end
  end

  // an unknown start value would leave the toggle unknown for good;
  // rst is only released while the host holds the link clock low
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      frame_tog_reg <= 1'b0;
    end else begin
      frame_tog_reg <= frame_tog_next;
    end
  end

  always_ff @(posedge link.sclk) begin
    bit_cnt_reg <= bit_cnt_next;
    lane_cnt_reg <= lane_cnt_next;
    op_reg <= op_next;
    adr_reg <= adr_next;
    ptr_reg <= ptr_next;
    sh_reg <= sh_next;
  end

  always_ff @(posedge link.sclk) begin
    if (mem_we) begin
      buf_mem[mem_idx] <= mem_wdata;
    end
  end

  // system domain
  logic cs_meta_reg, cs_sync_reg, cs_last_reg;
  logic bin_sys_meta_reg, bin_sys_reg;
  logic tog_meta_reg, tog_sync_reg;
  logic seen_reg, seen_next;
  logic frame_end, cmd_ok;
  bwpp_dev_state_t state_reg, state_next;
  logic [11:0] tmr_reg, tmr_next;
  logic [9:0] idx_reg, idx_next;
  logic [9:0] size_reg, size_next;
  logic buf2_reg, buf2_next;
  logic [PAGE_BITS-1:0] page_reg, page_next;
  logic err_reg, err_next;
  logic erase_reg, erase_next;
  logic we_reg, we_next;
  logic [7:0] data_reg, data_next;
  logic [BUF_ADR_BITS-1:0] badr_reg, badr_next;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_last_reg <= 1'b1;
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      bin_sys_meta_reg <= 1'b0;
      bin_sys_reg <= 1'b0;
    end else begin
      cs_meta_reg <= link.cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_last_reg <= cs_sync_reg;
      tog_meta_reg <= frame_tog_reg;
      tog_sync_reg <= tog_meta_reg;
      bin_sys_meta_reg <= binary_page_size;
      bin_sys_reg <= bin_sys_meta_reg;
    end
  end

  // the toggle filters select pulses that carried no clock edge at all;
  // frame words are read only after select rose, when the link clock is still
  assign frame_end = cs_sync_reg && !cs_last_reg && (tog_sync_reg != seen_reg);
  assign cmd_ok = op_program(op_reg) && bit_cnt_reg == HDR_BITS && lane_cnt_reg == 4'h0;

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    idx_next = idx_reg;
    size_next = size_reg;
    buf2_next = buf2_reg;
    page_next = page_reg;
    err_next = err_reg;
    erase_next = 1'b0;
    we_next = 1'b0;
    data_next = data_reg;
    badr_next = badr_reg;
    seen_next = (cs_sync_reg && !cs_last_reg) ? tog_sync_reg : seen_reg;
    case (state_reg)
      DEV_IDLE: begin
        if (frame_end && cmd_ok) begin
          err_next = 1'b0;
          idx_next = 10'h000;
          buf2_next = op_buf2(op_reg);
          if (bin_sys_reg) begin
            page_next = adr_reg[BIN_PAGE_LSB +: PAGE_BITS];
            size_next = BUF_SIZE_BIN;
          end else begin
            page_next = adr_reg[STD_PAGE_LSB +: PAGE_BITS];
            size_next = BUF_SIZE_STD;
          end
          if (op_erases(op_reg)) begin
            state_next = DEV_ERASE;
            erase_next = 1'b1;
            tmr_next = ERASE_CYC - 12'h001;
          end else begin
            state_next = DEV_PROG;
            tmr_next = BYTE_PROG_CYC - 12'h001;
          end
        end
      end
      DEV_ERASE: begin
        if (tmr_reg == 12'h000) begin
          if (cell_fail) begin
            err_next = 1'b1;
          end
          state_next = DEV_PROG;
          tmr_next = BYTE_PROG_CYC - 12'h001;
        end else begin
          tmr_next = tmr_reg - 12'h001;
        end
      end
      DEV_PROG: begin
        if (tmr_reg == 12'h000) begin
          we_next = 1'b1;
          badr_next = idx_reg;
          data_next = buf_mem[{1'b0, idx_reg} + (buf2_reg ? {1'b0, BUF_SIZE_STD} : 11'h000)];
          if (cell_fail) begin
            err_next = 1'b1;
          end
          if (idx_reg == size_reg - 10'h001) begin
            state_next = DEV_IDLE;
          end else begin
            idx_next = idx_reg + 10'h001;
            tmr_next = BYTE_PROG_CYC - 12'h001;
          end
        end else begin
          tmr_next = tmr_reg - 12'h001;
        end
      end
      default: state_next = DEV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= DEV_IDLE;
      tmr_reg <= 12'h000;
      idx_reg <= 10'h000;
      size_reg <= BUF_SIZE_STD;
      buf2_reg <= 1'b0;
      page_reg <= '0;
      err_reg <= 1'b0;
      erase_reg <= 1'b0;
      we_reg <= 1'b0;
      data_reg <= 8'h00;
      badr_reg <= '0;
      seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      idx_reg <= idx_next;
      size_reg <= size_next;
      buf2_reg <= buf2_next;
      page_reg <= page_next;
      err_reg <= err_next;
      erase_reg <= erase_next;
      we_reg <= we_next;
      data_reg <= data_next;
      badr_reg <= badr_next;
      seen_reg <= seen_next;
    end
  end

  // busy stays shown through the write pulse of the last byte
  assign ready_flag = (state_reg == DEV_IDLE) && !we_reg;
  assign erase_program_error_flag = err_reg;
  assign array_erase = erase_reg;
  assign array_prog_we = we_reg;
  assign main_page_address = page_reg;
  assign buffer_byte_address = badr_reg;
  assign array_data = data_reg;

endmodule // bwpp_device

// ---- rtl/bwpp_host.sv ----
// host controller end: frames commands and data onto the serial link
module bwpp_host (
  // serial link, clock made here
  bwpp_if.host link,
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input wire logic quad_width_enable_bit,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [23:0] cmd_addr,
  input wire logic [9:0] cmd_len,
  output logic cmd_refused,
  // write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data
);
  import bwpp_pkg::*;

  bwpp_hst_state_t state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [23:0] adr_reg, adr_next;
  logic [9:0] len_reg, len_next;
  logic [2:0] hdr_reg, hdr_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bits_reg, bits_next;
  logic [2:0] lanes_reg, lanes_next;
  logic [3:0] gap_reg, gap_next;
  logic cs_n_reg, cs_n_next;
  logic sclk_reg, sclk_next;
  logic [3:0] io_reg, io_next;
  logic [3:0] oe_reg, oe_next;
  logic refused_reg, refused_next;

  // msb-first lane word and enables for the current width
  function automatic logic [3:0] lane_word(input logic [7:0] sh, input logic [2:0] n);
    case (n)
      3'h4: lane_word = sh[7:4];
      3'h2: lane_word = {2'b00, sh[7:6]};
      default: lane_word = {3'b000, sh[7]};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input logic [2:0] n);
    case (n)
      3'h4: lane_oe = 4'hf;
      3'h2: lane_oe = 4'h3;
      default: lane_oe = 4'h1;
    endcase
  endfunction

  assign cmd_ready = (state_reg == HST_IDLE);
  assign wr_ready = (state_reg == HST_LOAD) && (hdr_reg == 3'(HDR_BYTES)) && (len_reg != 10'h000);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    adr_next = adr_reg;
    len_next = len_reg;
    hdr_next = hdr_reg;
    sh_next = sh_reg;
    bits_next = bits_reg;
    lanes_next = lanes_reg;
    gap_next = gap_reg;
    cs_n_next = cs_n_reg;
    sclk_next = 1'b0;
    io_next = io_reg;
    oe_next = oe_reg;
    refused_next = 1'b0;
    case (state_reg)
      HST_IDLE: begin
        if (cmd_valid) begin
          if (op_lanes(cmd_opcode) == 3'h4 && !quad_width_enable_bit) begin
            refused_next = 1'b1;
          end else begin
            op_next = cmd_opcode;
            adr_next = cmd_addr;
            len_next = cmd_len;
            hdr_next = 3'h0;
            cs_n_next = 1'b0;
            state_next = HST_LOAD;
          end
        end
      end
      HST_LOAD: begin
        bits_next = 4'h8;
        if (hdr_reg != 3'(HDR_BYTES)) begin
          case (hdr_reg)
            3'h0: sh_next = op_reg;
            3'h1: sh_next = adr_reg[23:16];
            3'h2: sh_next = adr_reg[15:8];
            default: sh_next = adr_reg[7:0];
          endcase
          hdr_next = hdr_reg + 3'h1;
          lanes_next = 3'h1;
          state_next = HST_LOW;
        end else if (len_reg == 10'h000) begin
          state_next = HST_END;
          gap_next = CS_GAP_CYC;
          cs_n_next = 1'b1;
          oe_next = 4'h0;
        end else if (wr_valid) begin
          // the clock simply pauses while the data source stalls
          sh_next = wr_data;
          len_next = len_reg - 10'h001;
          lanes_next = op_lanes(op_reg);
          state_next = HST_LOW;
        end
        if (state_next == HST_LOW) begin
          io_next = lane_word(sh_next, lanes_next);
          oe_next = lane_oe(lanes_next);
        end
      end
      HST_LOW: begin
        sclk_next = 1'b1;
        state_next = HST_HIGH;
      end
      HST_HIGH: begin
        bits_next = bits_reg - {1'b0, lanes_reg};
        sh_next = sh_reg << lanes_reg;
        if (bits_next == 4'h0) begin
          state_next = HST_LOAD;
        end else begin
          io_next = lane_word(sh_next, lanes_reg);
          state_next = HST_LOW;
        end
      end
      HST_END: begin
        if (gap_reg == 4'h0) begin
          state_next = HST_IDLE;
        end else begin
          gap_next = gap_reg - 4'h1;
        end
      end
      default: state_next = HST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= HST_IDLE;
      op_reg <= 8'h00;
      adr_reg <= 24'h000000;
      len_reg <= 10'h000;
      hdr_reg <= 3'h0;
      sh_reg <= 8'h00;
      bits_reg <= 4'h0;
      lanes_reg <= 3'h1;
      gap_reg <= 4'h0;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      adr_reg <= adr_next;
      len_reg <= len_next;
      hdr_reg <= hdr_next;
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      lanes_reg <= lanes_next;
      gap_reg <= gap_next;
      cs_n_reg <= cs_n_next;
      sclk_reg <= sclk_next;
      io_reg <= io_next;
      oe_reg <= oe_next;
      refused_reg <= refused_next;
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.io_out = io_reg;
  assign link.io_oe = oe_reg;
  assign cmd_refused = refused_reg;

endmodule // bwpp_host

// ---- dv/bwpp_monitor.sv ----
// checker for link framing and page commit timing
module bwpp_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // device status and array port
  input wire logic cell_fail,
  input wire logic ready_flag,
  input wire logic erase_program_error_flag,
  input wire logic array_erase,
  input wire logic array_prog_we
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_IDLE_CLOCK_LOW: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  AST_LANE0_DRIVEN: assert property (sclk |-> !cs_n && io_oe[0])
    else $error("clock edge without select or serial lane");
  // device samples on the rise, so lanes must not move while high
  AST_DATA_STEADY_HIGH: assert property (sclk |-> $stable(io_out) && $stable(io_oe))
    else $error("lane data moved while link clock high");
  AST_CLOCK_PULSE_ONE: assert property (sclk |=> !sclk)
    else $error("link clock high longer than one cycle");
  AST_START_AFTER_FRAME: assert property ($fell(ready_flag) |-> cs_n && $past(cs_n, 2))
    else $error("page operation started inside a frame");
  AST_START_PULSE: assert property ($fell(ready_flag) |-> ##[0:3] (array_erase || array_prog_we))
    else $error("busy without erase or program start");
  AST_BUSY_WHILE_WRITE: assert property ((array_erase || array_prog_we) |-> !ready_flag)
    else $error("array written while ready shown");
  AST_ERASE_QUIET: assert property (array_erase |=> (!array_prog_we && !array_erase && !ready_flag)[*8])
    else $error("erase interval cut short");
  AST_STEP_SPACING: assert property (array_prog_we |=> !array_prog_we [*2])
    else $error("byte program steps too close");
  AST_ERROR_CLEARED: assert property ($fell(ready_flag) |-> ##[0:1] !erase_program_error_flag)
    else $error("error flag not cleared at operation start");
  AST_FAIL_REPORTED: assert property (
    $rose(ready_flag) && $past(cell_fail, 2) |-> erase_program_error_flag)
    else $error("cell failure not reported");

  COV_ERASE: cover property (array_erase);
  COV_ERROR: cover property ($rose(erase_program_error_flag));
  COV_QUAD: cover property (sclk && io_oe == 4'hf);
endmodule // bwpp_monitor

// ---- dv/buffer_write_page_program_tb.sv ----
// testbench: host and device ends joined over the serial link
module buffer_write_page_program_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bwpp_pkg::*;
  logic sys_clk, rst, qe, bin, cell_fail, cmd_valid, cmd_ready, cmd_refused;
  logic wr_valid, wr_ready, ready_flag, erase_program_error_flag, array_erase, array_prog_we;
  logic [7:0] cmd_opcode, wr_data, array_data;
  logic [23:0] cmd_addr;
  logic [9:0] cmd_len, buffer_byte_address;
  logic [PAGE_BITS-1:0] main_page_address, exp_page;
  int bad_count, compares, we_seen, erase_seen, refused_seen, exp_idx, exp_buf, size;
  logic [7:0] mdl [0:1][0:527];
  logic [7:0] ld_op [6] = '{8'h84, 8'h87, 8'h24, 8'h27, 8'h44, 8'h47};
  logic [23:0] ld_adr [6] = '{24'h3fc20e, 24'h000014, 24'h000064, 24'h00020f, 24'h0000c8,
    24'h00012c};
  int ld_len [6] = '{4, 3, 3, 2, 3, 2};
  logic [7:0] ld_first [6] = '{8'h81, 8'h3c, 8'hc6, 8'h5a, 8'h17, 8'he8};
  logic [7:0] pg_op [6] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85};
  logic [23:0] pg_adr [6] = '{24'h6af000, 24'h8007ff, 24'h7ffc00, 24'h000000, 24'hcaabfe,
    24'h246810};
  int pg_len [6] = '{0, 0, 0, 0, 3, 2};
  int pg_er [6] = '{1, 1, 0, 0, 1, 1};
  logic pg_fail [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  bwpp_if link_if ();
  bwpp_host bwpp_host_inst (.link(link_if.host), .sys_clk(sys_clk), .rst(rst),
    .quad_width_enable_bit(qe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_refused(cmd_refused), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data));
  bwpp_device bwpp_device_inst (.link(link_if.dev), .sys_clk(sys_clk), .rst(rst),
    .quad_width_enable_bit(qe), .binary_page_size(bin), .cell_fail(cell_fail),
    .ready_flag(ready_flag), .erase_program_error_flag(erase_program_error_flag),
    .array_erase(array_erase), .array_prog_we(array_prog_we),
    .main_page_address(main_page_address), .buffer_byte_address(buffer_byte_address),
    .array_data(array_data));
  bwpp_monitor bwpp_monitor_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .io_out(link_if.io_out), .io_oe(link_if.io_oe),
    .cell_fail(cell_fail), .ready_flag(ready_flag),
    .erase_program_error_flag(erase_program_error_flag), .array_erase(array_erase),
    .array_prog_we(array_prog_we));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic sig(int which);
    case (which)
      0: return cmd_ready;
      1: return wr_ready;
      default: return ready_flag;
    endcase
  endfunction

  // returns just after an edge once the signal is high for the next edge
  task automatic wait_for(int which, int limit);
    int n;
    n = 0;
    while (sig(which) !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > limit) begin
        bad_count++;
        $display("CHECK FAILED wait %0d expected high seen timeout", which);
        conclude();
      end
    end
  endtask

  // one whole frame; the model follows what the device should store
  task automatic send(logic [7:0] op, logic [23:0] adr, int len, int bsel, logic store,
    logic [7:0] first);
    int pos;
    pos = bin ? int'(adr[8:0]) : int'(adr[9:0]);
    if (pos >= size) pos = 0;
    cmd_opcode = op;
    cmd_addr = adr;
    cmd_len = 10'(len);
    cmd_valid = 1'b1;
    wait_for(0, 5000);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (int i = 0; i < len; i++) begin
      wr_data = first + 8'(i);
      wr_valid = 1'b1;
      wait_for(1, 200);
      @(posedge sys_clk);
      #1;
      if (store) begin
        mdl[bsel][pos] = first + 8'(i);
        pos = (pos + 1) % size;
      end
    end
    wr_valid = 1'b0;
    wait_for(0, 200);
  endtask

  task automatic commit(logic [7:0] op, logic [23:0] adr, int len, int bsel, int er,
    logic fail);
    exp_page = bin ? adr[21:9] : adr[22:10];
    exp_buf = bsel;
    exp_idx = 0;
    we_seen = 0;
    erase_seen = 0;
    send(op, adr, len, bsel, len > 0, 8'h40 + 8'(len));
    // fail raised only once busy, so the start clears the flag first
    cell_fail = fail;
    check("busy", 32'h0, 32'(ready_flag));
    wait_for(2, 3000);
    cell_fail = 1'b0;
    check("erases", 32'(er), 32'(erase_seen));
    check("steps", 32'(size), 32'(we_seen));
    check("error flag", 32'(fail), 32'(erase_program_error_flag));
  endtask

  // array port follows the buffer model byte by byte
  always @(posedge sys_clk) begin
    if (!rst && array_erase) erase_seen++;
    if (!rst && cmd_refused) refused_seen++;
    if (!rst && array_prog_we) begin
      check("page", 32'(exp_page), 32'(main_page_address));
      check("byte", 32'(exp_idx), 32'(buffer_byte_address));
      if (exp_idx < 528 && !$isunknown(mdl[exp_buf][exp_idx])) begin
        check("data", 32'(mdl[exp_buf][exp_idx]), 32'(array_data));
      end
      exp_idx++;
      we_seen++;
    end
  end

  initial begin
    rst = 1'b1;
    qe = 1'b0;
    bin = 1'b0;
    cell_fail = 1'b0;
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = 24'h000000;
    cmd_len = 10'h000;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    bad_count = 0;
    compares = 0;
    refused_seen = 0;
    size = 528;
    exp_idx = 0;
    exp_buf = 0;
    exp_page = '0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    send(8'h47, 24'h000000, 0, 1, 1'b0, 8'h00);
    // the refusal pulse is counted one edge after the taking edge
    @(posedge sys_clk);
    #1;
    check("quad refused", 32'h1, 32'(refused_seen));
    qe = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 6; i++) begin
      send(ld_op[i], ld_adr[i], ld_len[i], i % 2, 1'b1, ld_first[i]);
    end
    for (int i = 0; i < 6; i++) begin
      // binary size is switched only while the link is idle
      if (i == 4) begin
        bin = 1'b1;
        size = 512;
        repeat (4) @(posedge sys_clk);
        #1;
      end
      // program-only targets are taken as already erased pages
      commit(pg_op[i], pg_adr[i], pg_len[i], i % 2, pg_er[i], pg_fail[i]);
    end
    conclude();
  end
endmodule // buffer_write_page_program_tb
